// >>> rtl/carb_core.v
`timescale 1ns/1ps
`default_nettype none
`include "carb_defines.vh"

// What this block does
// - sensor flag enabled by bits 8-10 per sensor
// - sensor flag set on threshold/window crossing
// - sensor flag cleared on new reading request
// - wake flag enabled bit0, set at countdown end
// - wake flag cleared on new logging countdown
// - done flag enabled bit2, set on DMA end
// - done flag cleared by status word read
// - full flag enabled when DMA bits 2,3 set
// - full flag set on loop fill, cleared on stop
// - nv-write-fail always enabled, read clears
// - command-fail always enabled, read clears
// - pending flag high while request outstanding
// - pending cleared when last transaction completes
// - busy flag high during internal transfers
// - arbitrate memory among SPI, RFID, DMA
// - SPI or RFID start preempts DMA
// - SPI and RFID transactions never preempted
// - SPI or RFID transaction finishes before next grant
// - SPI highest priority, then RFID
// - status word bit layout at address one
// - global mask bit disables all interrupts
// - incomplete transaction denies memory read: SPI gets 0xFFFF, RFID gets rfid_deny
module carb_core #(
  parameter NSENS = 3
) (
  input wire clk,
  input wire rstn,
  // configuration bits
  input wire [3*NSENS-1:0] sensor_ctrl_en,
  input wire wut_cfg_en,
  input wire [1:0] dma_cfg_en,
  input wire irq_dis,
  // event strobes
  input wire sensor_limit_ev,
  input wire [NSENS-1:0] sensor_limit_src,
  input wire sensor_read_req,
  input wire wut_done_ev,
  input wire wut_restart_ev,
  input wire autolog_on,
  input wire dma_done_ev,
  input wire log_full_ev,
  input wire log_stop_ev,
  input wire nv_fail_ev,
  input wire cmd_fail_ev,
  input wire core_req_ev,
  input wire core_done_ev,
  // status word access
  input wire status_rd,
  output reg [7:0] status_word,
  // requesters
  input wire spi_req,
  input wire spi_end,
  input wire spi_mem_rd,
  input wire rfid_req,
  input wire rfid_end,
  input wire rfid_mem_rd,
  input wire dma_req,
  input wire dma_end,
  input wire [15:0] mem_rdata,
  output wire spi_gnt,
  output wire rfid_gnt,
  output wire dma_gnt,
  output wire dma_abort,
  output reg [15:0] spi_rdata,
  output reg spi_rdata_valid,
  output reg rfid_deny,
  output reg irq
);

  reg [1:0] owner;
  reg [1:0] next_owner;
  reg spi_open;
  reg rfid_open;
  wire f_sensor;
  wire f_wake;
  wire f_done;
  wire f_full;
  wire f_nv;
  wire f_cmd;
  reg f_pending;
  wire [7:0] flags;
  wire [7:0] enables;
  wire sensor_hit;
  wire wake_countdown_flag;
  wire wake_set;
  wire wake_clr;
  wire done_set;
  wire full_set;
  integer i;
  reg sens_any;

  // width of one sensor's enable field
  localparam SENS_W = `CARB_SENSOR_EN_HI - `CARB_SENSOR_EN_LO + 1;

  // a limit event counts only for a sensor whose enable field is set
  always @* begin
    sens_any = 1'b0;
    for (i = 0; i < NSENS; i = i + 1) begin
      if (sensor_limit_src[i] && (|sensor_ctrl_en[SENS_W*i +: SENS_W])) begin
        sens_any = 1'b1;
      end
    end
  end

  assign sensor_hit = sensor_limit_ev && sens_any;

  // event gating by the configuration level at the moment of the event
  assign wake_set = wut_done_ev && wut_cfg_en;
  assign wake_clr = wut_restart_ev && autolog_on;
  assign done_set = dma_done_ev && dma_cfg_en[0];
  assign full_set = log_full_ev && (&dma_cfg_en);

  carb_flag u_sensor (
    .clk(clk),
    .rstn(rstn),
    .set_ev(sensor_hit),
    .clr_ev(sensor_read_req),
    .flag(f_sensor)
  );

  carb_flag u_wake (
    .clk(clk),
    .rstn(rstn),
    .set_ev(wake_set),
    .clr_ev(wake_clr),
    .flag(f_wake)
  );
  assign wake_countdown_flag = f_wake;

  carb_flag u_done (
    .clk(clk),
    .rstn(rstn),
    .set_ev(done_set),
    .clr_ev(status_rd),
    .flag(f_done)
  );

  carb_flag u_full (
    .clk(clk),
    .rstn(rstn),
    .set_ev(full_set),
    .clr_ev(log_stop_ev),
    .flag(f_full)
  );

  carb_flag u_nv (
    .clk(clk),
    .rstn(rstn),
    .set_ev(nv_fail_ev),
    .clr_ev(status_rd),
    .flag(f_nv)
  );

  carb_flag u_cmd (
    .clk(clk),
    .rstn(rstn),
    .set_ev(cmd_fail_ev),
    .clr_ev(status_rd),
    .flag(f_cmd)
  );

  // pending: a new request outranks a coincident completion
  always @(posedge clk) begin
    if (!rstn) begin
      f_pending <= 1'b0;
    end else if (core_req_ev) begin
      f_pending <= 1'b1;
    end else if (core_done_ev) begin
      f_pending <= 1'b0;
    end
  end

  // arbiter: SPI or RFID owner stays until its own end strobe; DMA also yields to an SPI or RFID request
  always @* begin
    next_owner = owner;
    case (owner)
      `CARB_GNT_NONE: begin
        if (spi_req) begin
          next_owner = `CARB_GNT_SPI;
        end else if (rfid_req) begin
          next_owner = `CARB_GNT_RFID;
        end else if (dma_req) begin
          next_owner = `CARB_GNT_DMA;
        end
      end
      `CARB_GNT_SPI: begin
        if (spi_end) begin
          next_owner = `CARB_GNT_NONE;
        end
      end
      `CARB_GNT_RFID: begin
        if (rfid_end) begin
          next_owner = `CARB_GNT_NONE;
        end
      end
      `CARB_GNT_DMA: begin
        if (spi_req) begin
          next_owner = `CARB_GNT_SPI;
        end else if (rfid_req) begin
          next_owner = `CARB_GNT_RFID;
        end else if (dma_end) begin
          next_owner = `CARB_GNT_NONE;
        end
      end
      default: begin
        next_owner = `CARB_GNT_NONE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      owner <= `CARB_GNT_NONE;
    end else begin
      owner <= next_owner;
    end
  end

  assign spi_gnt = (owner == `CARB_GNT_SPI);
  assign rfid_gnt = (owner == `CARB_GNT_RFID);
  assign dma_gnt = (owner == `CARB_GNT_DMA);
  // one-cycle pulse telling the DMA unit its transfer was cut
  assign dma_abort = dma_gnt && (spi_req || rfid_req);

  // per-channel open transaction, used to refuse overlapping reads
  always @(posedge clk) begin
    if (!rstn) begin
      spi_open <= 1'b0;
      rfid_open <= 1'b0;
    end else begin
      if (spi_gnt && spi_end) begin
        spi_open <= 1'b0;
      end else if (spi_gnt) begin
        spi_open <= 1'b1;
      end
      if (rfid_gnt && rfid_end) begin
        rfid_open <= 1'b0;
      end else if (rfid_gnt) begin
        rfid_open <= 1'b1;
      end
    end
  end

  // status reads are never refused, only memory reads
  always @(posedge clk) begin
    if (!rstn) begin
      spi_rdata <= 16'h0000;
      spi_rdata_valid <= 1'b0;
      rfid_deny <= 1'b0;
    end else begin
      spi_rdata_valid <= spi_mem_rd;
      rfid_deny <= rfid_mem_rd && rfid_open;
      if (spi_mem_rd) begin
        if (spi_open || !spi_gnt) begin
          spi_rdata <= `CARB_DENY_DATA;
        end else begin
          spi_rdata <= mem_rdata;
        end
      end
    end
  end

  // status word layout
  assign flags[`CARB_BIT_SENSOR] = f_sensor;
  assign flags[`CARB_BIT_WAKE] = wake_countdown_flag;
  assign flags[`CARB_BIT_DONE] = f_done;
  assign flags[`CARB_BIT_FULL] = f_full;
  assign flags[`CARB_BIT_NVFAIL] = f_nv;
  assign flags[`CARB_BIT_CMDFAIL] = f_cmd;
  assign flags[`CARB_BIT_PENDING] = f_pending;
  assign flags[`CARB_BIT_BUSY] = dma_gnt;
  // per-event enables are applied at set time; these gate the line
  // again, so clearing the wake, done or full enable, or all sensor fields, drops that flag's share of irq
  assign enables[`CARB_BIT_SENSOR] = |sensor_ctrl_en;
  assign enables[`CARB_BIT_WAKE] = wut_cfg_en;
  assign enables[`CARB_BIT_DONE] = dma_cfg_en[0];
  assign enables[`CARB_BIT_FULL] = &dma_cfg_en;
  assign enables[`CARB_BIT_NVFAIL] = 1'b1;
  assign enables[`CARB_BIT_CMDFAIL] = 1'b1;
  assign enables[`CARB_BIT_PENDING] = 1'b1;
  assign enables[`CARB_BIT_BUSY] = 1'b1;

  always @(posedge clk) begin
    if (!rstn) begin
      status_word <= `CARB_STATUS_RST;
    end else begin
      status_word <= flags;
    end
  end

  // irq uses the live flags, so it rises together with the status word
  always @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= !irq_dis && (|(flags & enables));
    end
  end

endmodule // carb_core

`default_nettype wire

// >>> shared/carb_defines.vh
`ifndef CARB_DEFINES_VH
`define CARB_DEFINES_VH

// status word bit positions (internal address 1)
`define CARB_STATUS_ADDR 1'h1
`define CARB_BIT_SENSOR 7
`define CARB_BIT_WAKE 6
`define CARB_BIT_DONE 5
`define CARB_BIT_FULL 4
`define CARB_BIT_NVFAIL 3
`define CARB_BIT_CMDFAIL 2
`define CARB_BIT_PENDING 1
`define CARB_BIT_BUSY 0

// enable bit positions inside configuration words
`define CARB_SENSOR_EN_LO 8
`define CARB_SENSOR_EN_HI 10
`define CARB_WAKE_EN_BIT 0
`define CARB_DMA_DONE_EN_BIT 2
`define CARB_DMA_LOOP_EN_BIT 3

// data answered to a denied memory read
`define CARB_DENY_DATA 16'hFFFF

// status word value after reset
`define CARB_STATUS_RST 8'h00

// grant encodings
`define CARB_GNT_NONE 2'h0
`define CARB_GNT_SPI 2'h1
`define CARB_GNT_RFID 2'h2
`define CARB_GNT_DMA 2'h3

`endif

// >>> rtl/carb_flag.v
`timescale 1ns/1ps
`default_nettype none

// sticky flag: set wins over clear so a coincident event is kept
module carb_flag (
  input wire clk,
  input wire rstn,
  input wire set_ev,
  input wire clr_ev,
  output reg flag
);

  always @(posedge clk) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set_ev) begin
      flag <= 1'b1;
    end else if (clr_ev) begin
      flag <= 1'b0;
    end
  end

endmodule // carb_flag

`default_nettype wire

// >>> bench/carb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory side: data moves every cycle so a stale capture shows up
module carb_mem_model (
  input wire logic clk,
  output logic [15:0] mem_rdata
);
  initial mem_rdata = 16'hA5C3;
  always @(posedge clk) mem_rdata <= mem_rdata + 16'h1357;
endmodule // carb_mem_model
`default_nettype wire

// >>> bench/carb_chk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module carb_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_dis,
  input wire logic spi_req,
  input wire logic rfid_req,
  input wire logic spi_end,
  input wire logic rfid_end,
  input wire logic spi_gnt,
  input wire logic rfid_gnt,
  input wire logic dma_gnt,
  input wire logic dma_abort,
  input wire logic dma_done_ev,
  input wire logic [1:0] dma_cfg_en,
  input wire logic rfid_mem_rd,
  input wire logic rfid_deny,
  input wire logic [7:0] status_word,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_idle;
    !spi_gnt && !rfid_gnt && !dma_gnt;
  endsequence
  sequence s_done_ev;
    dma_done_ev && dma_cfg_en[0];
  endsequence
  a_gnt_onehot: assert property ($onehot0({spi_gnt, rfid_gnt, dma_gnt}))
    else $error("two grants");
  a_spi_first: assert property (s_idle ##0 spi_req |=> spi_gnt)
    else $error("spi not first");
  a_rfid_next: assert property (s_idle ##0 !spi_req && rfid_req |=> rfid_gnt)
    else $error("rfid not next");
  a_spi_kept: assert property (spi_gnt && !spi_end |=> spi_gnt)
    else $error("spi cut");
  a_rfid_kept: assert property (rfid_gnt && !rfid_end |=> rfid_gnt)
    else $error("rfid cut");
  a_end_frees: assert property (spi_gnt && spi_end |=> s_idle)
    else $error("no idle gap");
  a_dma_preempt: assert property (dma_gnt && (spi_req || rfid_req)
    |-> dma_abort ##1 (spi_gnt || rfid_gnt))
    else $error("no abort");
  a_done_shown: assert property (s_done_ev |-> ##2 status_word[5])
    else $error("done flag lost");
  a_busy_set: assert property (dma_gnt |=> status_word[0])
    else $error("busy missing");
  a_busy_clear: assert property (!dma_gnt |=> !status_word[0])
    else $error("busy stuck");
  a_deny_idle: assert property (!rfid_mem_rd |=> !rfid_deny)
    else $error("deny without read");
  a_irq_masked: assert property (irq_dis [*2] |=> !irq)
    else $error("irq unmasked");
endmodule // carb_chk
bind carb_core carb_chk i_carb_chk (.clk, .rstn, .irq_dis, .spi_req, .rfid_req, .spi_end,
  .rfid_end, .spi_gnt, .rfid_gnt, .dma_gnt, .dma_abort, .dma_done_ev, .dma_cfg_en,
  .rfid_mem_rd, .rfid_deny, .status_word, .irq);
`default_nettype wire

// >>> bench/test_core_arbiter_irq_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_core_arbiter_irq_status;
  logic clk = 0, rstn = 0, wut_cfg_en = 1, autolog_on = 1, irq_dis = 0, spi_mem_rd = 0;
  logic rfid_mem_rd = 0;
  logic [8:0] sensor_ctrl_en = 9'h1FF;
  logic [2:0] src = 3'h1, req = 3'h0, fin = 3'h0;
  logic [1:0] dma_cfg_en = 2'h3;
  logic [11:0] e = 12'h0;
  logic [15:0] m;
  wire [15:0] mem_rdata, spi_rdata;
  wire [7:0] sw;
  wire sg, rg, dg, ab, rv, dn, irq;
  int n_errors = 0, n_compared = 0, k;
  int st[7] = '{0, 2, 4, 5, 7, 8, 9};
  int cl[7] = '{1, 3, 11, 6, 11, 11, 10};
  initial begin
    forever #2.5 clk = ~clk;
  end
  carb_mem_model i_carb_mem_model (.clk, .mem_rdata);
  carb_core i_carb_core (.clk, .rstn, .sensor_ctrl_en, .wut_cfg_en, .dma_cfg_en, .irq_dis,
    .sensor_limit_ev(e[0]), .sensor_limit_src(src), .sensor_read_req(e[1]),
    .wut_done_ev(e[2]), .wut_restart_ev(e[3]), .autolog_on, .dma_done_ev(e[4]),
    .log_full_ev(e[5]), .log_stop_ev(e[6]), .nv_fail_ev(e[7]), .cmd_fail_ev(e[8]),
    .core_req_ev(e[9]), .core_done_ev(e[10]), .status_rd(e[11]), .status_word(sw),
    .spi_req(req[0]), .spi_end(fin[0]), .spi_mem_rd, .rfid_req(req[1]), .rfid_end(fin[1]),
    .rfid_mem_rd, .dma_req(req[2]), .dma_end(fin[2]), .mem_rdata, .spi_gnt(sg),
    .rfid_gnt(rg), .dma_gnt(dg), .dma_abort(ab), .spi_rdata, .spi_rdata_valid(rv),
    .rfid_deny(dn), .irq);
  function automatic logic exp_sens(input logic [8:0] en, input logic [2:0] s);
    exp_sens = 0;
    for (int j = 0; j < 3; j++) begin
      if (s[j] && en[3*j+:3] != 3'h0) exp_sens = 1;
    end
  endfunction
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // flag moves at the next edge, status word one edge later
  task automatic pulse(input logic [11:0] p);
    e = p;
    cyc(1);
    e = 12'h0;
    cyc(1);
  endtask
  task automatic wgnt(input logic [2:0] g);
    k = 0;
    while ({dg, rg, sg} !== g && k < 20) begin
      cyc(1);
      k++;
    end
    if ({dg, rg, sg} !== g) begin
      n_errors++;
      finish_test();
    end
  endtask
  initial begin
    k = $urandom(46782);
    cyc(2);
    rstn = 1;
    for (int i = 0; i < 7; i++) begin
      pulse(12'h1 << st[i]);
      chk(sw[7-i], 1);
      chk(irq, 1);
      pulse(12'h1 << cl[i]);
      chk(sw, 0);
    end
    pulse(12'h810);
    chk(sw[5], 1);
    pulse(12'h800);
    dma_cfg_en = 2'h1;
    wut_cfg_en = 0;
    pulse(12'h034);
    chk(sw, 8'h20);
    dma_cfg_en = 2'h2;
    pulse(12'h830);
    chk(sw, 0);
    dma_cfg_en = 2'h3;
    wut_cfg_en = 1;
    irq_dis = 1;
    pulse(12'h100);
    chk({irq, sw}, 9'h004);
    irq_dis = 0;
    cyc(2);
    chk(irq, 1);
    pulse(12'h800);
    repeat (8) begin
      sensor_ctrl_en = 9'($urandom);
      src = 3'($urandom);
      pulse(12'h1);
      chk(sw[7], exp_sens(sensor_ctrl_en, src));
      pulse(12'h2);
    end
    autolog_on = 0;
    pulse(12'h004);
    pulse(12'h008);
    chk(sw[6], 1);
    wut_cfg_en = 0;
    cyc(1);
    chk({irq, sw[6]}, 2'h1);
    wut_cfg_en = 1;
    autolog_on = 1;
    pulse(12'h008);
    chk(sw[6], 0);
    $display("flag test done");
    req = 3'h7;
    wgnt(3'h1);
    chk({dg, rg, sg}, 3'h1);
    spi_mem_rd = 1;
    m = mem_rdata;
    cyc(1);
    chk({rv, spi_rdata}, {1'b1, m});
    cyc(1);
    spi_mem_rd = 0;
    chk(spi_rdata, 16'hFFFF);
    cyc(3);
    chk(sg, 1);
    req = 3'h6;
    fin = 3'h1;
    cyc(1);
    fin = 3'h0;
    wgnt(3'h2);
    chk(rg, 1);
    rfid_mem_rd = 1;
    cyc(1);
    chk(dn, 0);
    cyc(1);
    rfid_mem_rd = 0;
    chk(dn, 1);
    req = 3'h7;
    cyc(3);
    chk(rg, 1);
    req = 3'h5;
    fin = 3'h2;
    cyc(1);
    fin = 3'h0;
    wgnt(3'h1);
    chk({dg, sg}, 2'h1);
    req = 3'h4;
    fin = 3'h1;
    cyc(1);
    fin = 3'h0;
    wgnt(3'h4);
    cyc(2);
    chk(sw[0], 1);
    req = 3'h6;
    #1;
    chk(ab, 1);
    wgnt(3'h2);
    chk(rg, 1);
    req = 3'h0;
    fin = 3'h2;
    cyc(1);
    fin = 3'h0;
    wgnt(3'h0);
    req = 3'h4;
    wgnt(3'h4);
    req = 3'h0;
    fin = 3'h4;
    cyc(1);
    fin = 3'h0;
    chk({dg, rg, sg}, 3'h0);
    cyc(1);
    chk(sw[0], 0);
    $display("arbiter test done");
    finish_test();
  end
endmodule // test_core_arbiter_irq_status
`default_nettype wire
